// >>> rtl/ppsel_pkg.sv
/*
 * Package for the peripheral interrupt priority selector: register offsets,
 * field positions, reset values and the carrier structs.
 * Assumes a plain strobe register port with 8-bit data.
 */
package ppsel_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map (byte offsets on the plain port)
    localparam logic [3:0] ADDR_PRIO_ONE  = 4'h0;
    localparam logic [3:0] ADDR_PRIO_TWO  = 4'h1;
    localparam logic [3:0] ADDR_PRIO_CTRL = 4'h2;
    localparam logic [3:0] ADDR_STATUS    = 4'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions, first priority register
    localparam int BIT_PARALLEL_SLAVE = 7;
    localparam int BIT_CONVERTER_DONE = 6;
    localparam int BIT_SERIAL_RECEIVE = 5;
    localparam int BIT_SERIAL_TRANSMIT = 4;
    localparam int BIT_SYNC_SERIAL    = 3;
    localparam int BIT_CAPTURE_ONE    = 2;
    localparam int BIT_TIMER_TWO      = 1;
    localparam int BIT_TIMER_ONE      = 0;
    // Field positions, second priority register
    localparam int BIT_OSC_FAIL       = 7;
    localparam int BIT_COMPARATOR     = 6;
    localparam int BIT_BUS_COLLISION  = 3;
    localparam int BIT_VOLTAGE_DETECT = 2;
    localparam int BIT_TIMER_THREE    = 1;
    localparam int BIT_CAPTURE_TWO    = 0;
    // Field position of the enable in the control register
    localparam int BIT_LEVELS_ENABLE  = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Implemented-bit masks and reset values
    localparam logic [7:0] MASK_PRIO_ONE_FULL  = 8'hFF;
    localparam logic [7:0] MASK_PRIO_ONE_SMALL = 8'h7F;
    localparam logic [7:0] MASK_PRIO_TWO       = 8'hCF;
    localparam logic [7:0] RESET_PRIO          = 8'hFF;
    localparam logic       RESET_LEVELS_ENABLE = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Carrier types
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ppsel_req_s;

    typedef struct packed {
        logic [7:0] high_one;
        logic [7:0] high_two;
    } ppsel_route_s;

endpackage

// >>> rtl/ppsel_prio_reg.sv
/*
 * One 8-bit priority register: write with implemented-bit mask,
 * unimplemented positions held at zero.
 * Assumes the write strobe is a one-cycle pulse on clk_in.
 */
`timescale 1ns/10ps
module ppsel_prio_reg #(
    parameter logic [7:0] IMPL_MASK = 8'hFF,
    parameter logic [7:0] RST_VALUE = 8'hFF
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // Write side
    input  wire logic       wr_in,
    input  wire logic [7:0] wdata_in,
    // Stored value
    output logic      [7:0] value_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage; masked bits can never become one
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            value_out <= RST_VALUE & IMPL_MASK;
        end else if (wr_in) begin
            value_out <= wdata_in & IMPL_MASK;
        end
    end

endmodule

// >>> rtl/ppsel_top.sv
/*
 * Peripheral interrupt priority selector. Holds two per-source priority
 * registers and the priority-levels enable, and routes each peripheral
 * request to the high or low interrupt level of the core.
 * Assumes requests are already flagged and enabled upstream, on clk_in.
 */
// The placing of the registers and the plain strobed port are this design's own decisions.
// Behaviour
// - Priority bits ignored unless levels enable set; while it is clear every source is unranked.
// - Per-source priority bits are split over two priority registers.
// - Priority bit one routes source high, zero routes it low.
// - First register bits 7..0: parallel, converter, rx, tx, sync, cap1, tmr2, tmr1.
// - Second register: osc fail 7, comparator 6, collision 3, voltage 2, tmr3 1, cap2 0.
// - Unimplemented bits read zero: second register 5-4, parallel bit on small package.
// - Levels enable lives in the reset-cause register; clear means single-level mode.
`timescale 1ns/10ps
module ppsel_top #(
    parameter bit SMALL_PACKAGE = 1'b0
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // Register port
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // Peripheral requests, first and second register order
    input  wire logic [7:0] req_one_in,
    input  wire logic [7:0] req_two_in,
    // Level requests to the core
    output logic            high_irq_out,
    output logic            low_irq_out,
    output logic            levels_enable_out
);

    localparam logic [7:0] ONE_MASK = SMALL_PACKAGE ? ppsel_pkg::MASK_PRIO_ONE_SMALL
                                                    : ppsel_pkg::MASK_PRIO_ONE_FULL;

    ppsel_pkg::ppsel_req_s   req;
    ppsel_pkg::ppsel_route_s route;
    logic                    levels_enable;
    logic                    wr_one;
    logic                    wr_two;
    logic                    wr_ctrl;
    logic [7:0]              next_rdata;
    logic [7:0]              next_high;
    logic [7:0]              next_low;
    // Per-source priority bits by name
    logic                    parallel_slave_prio;
    logic                    converter_done_prio;
    logic                    serial_receive_prio;
    logic                    serial_transmit_prio;
    logic                    sync_serial_prio;
    logic                    capture_unit_one_prio;
    logic                    timer_two_match_prio;
    logic                    timer_one_overflow_prio;
    logic                    oscillator_fail_prio;
    logic                    comparator_prio;
    logic                    bus_collision_prio;
    logic                    voltage_detect_prio;
    logic                    timer_three_overflow_prio;
    logic                    capture_unit_two_prio;
    // Priority bits regathered in register order, empty slots cleared
    logic [7:0]              prio_one;
    logic [7:0]              prio_two;
    // Per-slot level requests
    logic [7:0]              high_one_src;
    logic [7:0]              low_one_src;
    logic [7:0]              high_two_src;
    logic [7:0]              low_two_src;

    assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    ////////////////////////////////////////////////////////////////////////////
    // Write decode
    function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
        hit = (a == b);
    endfunction

    always_comb begin
        wr_one  = 1'b0;
        wr_two  = 1'b0;
        wr_ctrl = 1'b0;
        if (req.wr && hit(req.addr, ppsel_pkg::ADDR_PRIO_ONE)) begin
            wr_one = 1'b1;
        end else if (req.wr && hit(req.addr, ppsel_pkg::ADDR_PRIO_TWO)) begin
            wr_two = 1'b1;
        end else if (req.wr && hit(req.addr, ppsel_pkg::ADDR_PRIO_CTRL)) begin
            wr_ctrl = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The two priority registers
    ppsel_prio_reg #(
        .IMPL_MASK (ONE_MASK),
        .RST_VALUE (ppsel_pkg::RESET_PRIO)
    ) u_prio_one (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .wr_in     (wr_one),
        .wdata_in  (req.wdata),
        .value_out (route.high_one)
    );

    ppsel_prio_reg #(
        .IMPL_MASK (ppsel_pkg::MASK_PRIO_TWO),
        .RST_VALUE (ppsel_pkg::RESET_PRIO)
    ) u_prio_two (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .wr_in     (wr_two),
        .wdata_in  (req.wdata),
        .value_out (route.high_two)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Priority-levels enable, the reset-cause register's top bit
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            levels_enable <= ppsel_pkg::RESET_LEVELS_ENABLE;
        end else if (wr_ctrl) begin
            levels_enable <= req.wdata[ppsel_pkg::BIT_LEVELS_ENABLE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; data stand the cycle after the read strobe only
    always_comb begin
        next_rdata = 8'h00;
        if (req.rd && hit(req.addr, ppsel_pkg::ADDR_PRIO_ONE)) begin
            next_rdata = route.high_one & ONE_MASK;
        end else if (req.rd && hit(req.addr, ppsel_pkg::ADDR_PRIO_TWO)) begin
            next_rdata = route.high_two & ppsel_pkg::MASK_PRIO_TWO;
        end else if (req.rd && hit(req.addr, ppsel_pkg::ADDR_PRIO_CTRL)) begin
            next_rdata[ppsel_pkg::BIT_LEVELS_ENABLE] = levels_enable;
        end else if (req.rd && hit(req.addr, ppsel_pkg::ADDR_STATUS)) begin
            next_rdata = {6'h00, low_irq_out, high_irq_out};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-source priority bits, first register, bit 7 down to bit 0
    assign parallel_slave_prio       = route.high_one[ppsel_pkg::BIT_PARALLEL_SLAVE];
    assign converter_done_prio       = route.high_one[ppsel_pkg::BIT_CONVERTER_DONE];
    assign serial_receive_prio       = route.high_one[ppsel_pkg::BIT_SERIAL_RECEIVE];
    assign serial_transmit_prio      = route.high_one[ppsel_pkg::BIT_SERIAL_TRANSMIT];
    assign sync_serial_prio          = route.high_one[ppsel_pkg::BIT_SYNC_SERIAL];
    assign capture_unit_one_prio     = route.high_one[ppsel_pkg::BIT_CAPTURE_ONE];
    assign timer_two_match_prio      = route.high_one[ppsel_pkg::BIT_TIMER_TWO];
    assign timer_one_overflow_prio   = route.high_one[ppsel_pkg::BIT_TIMER_ONE];

    // Per-source priority bits, second register; slots 5 and 4 have no source
    assign oscillator_fail_prio      = route.high_two[ppsel_pkg::BIT_OSC_FAIL];
    assign comparator_prio           = route.high_two[ppsel_pkg::BIT_COMPARATOR];
    assign bus_collision_prio        = route.high_two[ppsel_pkg::BIT_BUS_COLLISION];
    assign voltage_detect_prio       = route.high_two[ppsel_pkg::BIT_VOLTAGE_DETECT];
    assign timer_three_overflow_prio = route.high_two[ppsel_pkg::BIT_TIMER_THREE];
    assign capture_unit_two_prio     = route.high_two[ppsel_pkg::BIT_CAPTURE_TWO];

    // Regather the named bits in register order; empty slots stay zero, and the impl
    // gate in level_of keeps a stray request pin on a missing source from either level
    always_comb begin
        prio_one = 8'h00;
        prio_two = 8'h00;
        prio_one[ppsel_pkg::BIT_PARALLEL_SLAVE]  = parallel_slave_prio;
        prio_one[ppsel_pkg::BIT_CONVERTER_DONE]  = converter_done_prio;
        prio_one[ppsel_pkg::BIT_SERIAL_RECEIVE]  = serial_receive_prio;
        prio_one[ppsel_pkg::BIT_SERIAL_TRANSMIT] = serial_transmit_prio;
        prio_one[ppsel_pkg::BIT_SYNC_SERIAL]     = sync_serial_prio;
        prio_one[ppsel_pkg::BIT_CAPTURE_ONE]     = capture_unit_one_prio;
        prio_one[ppsel_pkg::BIT_TIMER_TWO]       = timer_two_match_prio;
        prio_one[ppsel_pkg::BIT_TIMER_ONE]       = timer_one_overflow_prio;
        prio_two[ppsel_pkg::BIT_OSC_FAIL]        = oscillator_fail_prio;
        prio_two[ppsel_pkg::BIT_COMPARATOR]      = comparator_prio;
        prio_two[ppsel_pkg::BIT_BUS_COLLISION]   = bus_collision_prio;
        prio_two[ppsel_pkg::BIT_VOLTAGE_DETECT]  = voltage_detect_prio;
        prio_two[ppsel_pkg::BIT_TIMER_THREE]     = timer_three_overflow_prio;
        prio_two[ppsel_pkg::BIT_CAPTURE_TWO]     = capture_unit_two_prio;
        prio_one = prio_one & ONE_MASK;
        prio_two = prio_two & ppsel_pkg::MASK_PRIO_TWO;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Level routing of pending requests

    // Route one slot, result {low, high}. Without ranking every source lands
    // on the high level, which the core then treats as its only level.
    function automatic logic [1:0] level_of(input logic pending,
                                            input logic prio,
                                            input logic impl,
                                            input logic ranked);
        level_of = 2'b00;
        if (pending && impl) begin
            if (!ranked || prio) begin
                level_of = 2'b01;
            end else begin
                level_of = 2'b10;
            end
        end
    endfunction

    // One routing cell per register slot
    for (genvar g = 0; g < 8; g++) begin : g_slot
        assign {low_one_src[g], high_one_src[g]} =
            level_of(req_one_in[g], prio_one[g], ONE_MASK[g], levels_enable);
        assign {low_two_src[g], high_two_src[g]} =
            level_of(req_two_in[g], prio_two[g],
                     ppsel_pkg::MASK_PRIO_TWO[g], levels_enable);
    end

    // A level is requested when any slot asks for it
    always_comb begin
        next_high = high_one_src | high_two_src;
        next_low  = low_one_src | low_two_src;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            high_irq_out      <= 1'b0;
            low_irq_out       <= 1'b0;
            levels_enable_out <= ppsel_pkg::RESET_LEVELS_ENABLE;
        end else begin
            high_irq_out      <= |next_high;
            low_irq_out       <= |next_low;
            levels_enable_out <= levels_enable;
        end
    end

endmodule

// >>> testbench/ppsel_core_model.sv
/* Core vectoring model: takes the high level first, then the low one.
   Assumes level requests registered on clk_in. */
`timescale 1ns/10ps
module ppsel_core_model (
    // Clock, reset and level requests
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       high_irq_in,
    input  wire logic       low_irq_in,
    // Vector taken: 1 high, 2 low, 0 none
    output logic      [1:0] vector_out
);
    // High level preempts low, as the core arbitrates
    always_ff @(posedge clk_in) begin
        if (rst_in) vector_out <= 2'h0;
        else vector_out <= high_irq_in ? 2'h1 : (low_irq_in ? 2'h2 : 2'h0);
    end
endmodule

// >>> testbench/ppsel_monitor.sv
/* Port checker for the priority selector.
   Assumes it is bound to ppsel_top and sampled on clk_in. */
`timescale 1ns/10ps
module ppsel_monitor #(
    parameter bit SMALL_PACKAGE = 1'b0
) (
    // Watched ports
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic [3:0] addr_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] rdata_out,
    input wire logic [7:0] req_one_in,
    input wire logic [7:0] req_two_in,
    input wire logic       high_irq_out,
    input wire logic       low_irq_out,
    input wire logic       levels_enable_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // First-register slots that exist in this package variant
    localparam logic [7:0] ONE_MASK = SMALL_PACKAGE ? 8'h7F : 8'hFF;
    // Any live request, ignoring the empty slots of both registers
    wire logic any_req = ((req_one_in & ONE_MASK) | (req_two_in & 8'hCF)) != 8'h00;
    ////////////////////////////////////////////////////////////////////////////
    a_read_idle: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("rdata not idle");
    a_quiet_idle: assert property (!any_req |=> !high_irq_out && !low_irq_out)
        else $error("irq without request");
    a_req_routed: assert property (any_req |=> high_irq_out || low_irq_out)
        else $error("request dropped");
    a_single_level: assert property (!levels_enable_out |-> !low_irq_out)
        else $error("low level used while disabled");
    a_gap_zero: assert property (rd_in && addr_in == 4'h1 |=> rdata_out[5:4] == 2'h0)
        else $error("gap bits set");
    a_ctrl_read: assert property (rd_in && addr_in == 4'h2
        |=> rdata_out == {levels_enable_out, 7'h00}) else $error("control readback");
    a_status_read: assert property (rd_in && addr_in == 4'h3
        |=> rdata_out == {6'h00, $past(low_irq_out), $past(high_irq_out)}) else $error("status");
    a_enable_lag: assert property (wr_in && addr_in == 4'h2
        |=> ##1 levels_enable_out == $past(wdata_in[7], 2)) else $error("enable lag");
    c_low: cover property (low_irq_out);
    c_high_ranked: cover property (levels_enable_out && high_irq_out);
    c_read_one: cover property (rd_in && addr_in == 4'h0);
endmodule
bind ppsel_top ppsel_monitor #(
    .SMALL_PACKAGE (SMALL_PACKAGE)
) u_mon (
    .clk_in            (clk_in),
    .rst_in            (rst_in),
    .addr_in           (addr_in),
    .wr_in             (wr_in),
    .rd_in             (rd_in),
    .wdata_in          (wdata_in),
    .rdata_out         (rdata_out),
    .req_one_in        (req_one_in),
    .req_two_in        (req_two_in),
    .high_irq_out      (high_irq_out),
    .low_irq_out       (low_irq_out),
    .levels_enable_out (levels_enable_out)
);

// >>> testbench/ppsel_tb_top.sv
/* Self-checking bench for ppsel_top with a core vectoring model.
   Assumes the plain strobe register port; both package variants run side by side. */
`timescale 1ns/10ps
module ppsel_tb_top;
    logic       clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00, req_one_in = 8'h00, req_two_in = 8'h00, rdata_out;
    logic       high_irq_out, low_irq_out, levels_enable_out;
    logic [7:0] rdata_small;
    logic       high_small, low_small, enable_small;
    logic [1:0] vector, lv;
    int         fails = 0, n_compared = 0, p1, p2, en, r1, r2, a, d, i;
    always #50 clk_in = ~clk_in;
    ppsel_top u_dut (
        .clk_in            (clk_in),
        .rst_in            (rst_in),
        .addr_in           (addr_in),
        .wdata_in          (wdata_in),
        .wr_in             (wr_in),
        .rd_in             (rd_in),
        .rdata_out         (rdata_out),
        .req_one_in        (req_one_in),
        .req_two_in        (req_two_in),
        .high_irq_out      (high_irq_out),
        .low_irq_out       (low_irq_out),
        .levels_enable_out (levels_enable_out)
    );
    // Smaller package variant: the top slot of the first register is absent
    ppsel_top #(
        .SMALL_PACKAGE (1'b1)
    ) u_small (
        .clk_in            (clk_in),
        .rst_in            (rst_in),
        .addr_in           (addr_in),
        .wdata_in          (wdata_in),
        .wr_in             (wr_in),
        .rd_in             (rd_in),
        .rdata_out         (rdata_small),
        .req_one_in        (req_one_in),
        .req_two_in        (req_two_in),
        .high_irq_out      (high_small),
        .low_irq_out       (low_small),
        .levels_enable_out (enable_small)
    );
    ppsel_core_model u_core (.clk_in(clk_in), .rst_in(rst_in), .high_irq_in(high_irq_out),
        .low_irq_in(low_irq_out), .vector_out(vector));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            fails++;
        end
    endtask
    // One strobe cycle; leaves time just after the answering edge
    task automatic bus(input logic w, input logic [3:0] ad, input logic [7:0] dt);
        @(posedge clk_in);
        wr_in <= w;
        rd_in <= !w;
        addr_in <= ad;
        wdata_in <= dt;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #10;
    endtask
    // Expected {low, high} from the integer model; m masks the first register
    function automatic logic [1:0] route(input int m);
        int s1;
        s1 = r1 & m;
        if (en == 0) return {1'b0, (s1 | (r2 & 'hCF)) != 0};
        return {((s1 & ~p1) | (r2 & ~p2 & 'hCF)) != 0, ((s1 & p1) | (r2 & p2 & 'hCF)) != 0};
    endfunction
    function automatic logic [7:0] exp_rd(input int ad, input int m);
        case (ad)
            0: return p1[7:0] & m[7:0];
            1: return p2[7:0];
            2: return en ? 8'h80 : 8'h00;
            3: return {6'h00, route(m)};
            default: return 8'h00;
        endcase
    endfunction
    task automatic do_reset();
        rst_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        p1 = 'hFF;
        p2 = 'hCF;
        en = 0;
        for (a = 0; a < 4; a++) begin
            bus(1'b0, a[3:0], 8'h00);
            chk("reset value", rdata_out, exp_rd(a, 'hFF));
            chk("small reset value", rdata_small, exp_rd(a, 'h7F));
        end
        chk("reset enable", {7'h00, levels_enable_out}, 8'h00);
    endtask
    task automatic end_sim();
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #1000000;
        fails++;
        end_sim();
    end
    // Random writes, readbacks and request patterns against the model
    initial begin
        void'($urandom(32'hA58EE4C5));
        r1 = 0;
        r2 = 0;
        do_reset();
        for (i = 0; i < 200; i++) begin
            a = $urandom_range(0, 15);
            d = $urandom & 'hFF;
            bus(1'b1, a[3:0], d[7:0]);
            if (a == 0) p1 = d;
            if (a == 1) p2 = d & 'hCF;
            if (a == 2) en = d >> 7;
            bus(1'b0, a[3:0], 8'h00);
            chk("readback", rdata_out, exp_rd(a, 'hFF));
            chk("small readback", rdata_small, exp_rd(a, 'h7F));
            r1 = $urandom & 'hFF;
            r2 = $urandom & 'hFF;
            @(posedge clk_in);
            req_one_in <= r1[7:0];
            req_two_in <= r2[7:0];
            repeat (3) @(posedge clk_in);
            #10;
            lv = route('hFF);
            chk("levels", {6'h00, low_irq_out, high_irq_out}, {6'h00, lv});
            chk("small levels", {6'h00, low_small, high_small}, {6'h00, route('h7F)});
            chk("vector", {6'h00, vector}, lv[0] ? 8'h01 : {6'h00, lv});
            chk("enable out", {7'h00, levels_enable_out}, en[7:0]);
            chk("small enable out", {7'h00, enable_small}, en[7:0]);
        end
        @(posedge clk_in);
        do_reset();
        end_sim();
    end
endmodule
